/* File: rtl/tc_pkg.sv */
// tc_pkg: constants, offsets, reset values and types of the 16-bit timer counter
package tc_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int TC_DW = 8;
	localparam int TC_CW = 16;
	localparam int TC_AW = 4;
	localparam int TC_PRE_W = 10;

	// ----------------------------------------
	// byte locations on the 8-bit bus
	// ----------------------------------------
	localparam logic [3:0] TC_ADDR_CTRL_A = 4'h0;
	localparam logic [3:0] TC_ADDR_CTRL_B = 4'h1;
	localparam logic [3:0] TC_ADDR_CNT_L = 4'h4;
	localparam logic [3:0] TC_ADDR_CNT_H = 4'h5;
	localparam logic [3:0] TC_ADDR_CAP_L = 4'h6;
	localparam logic [3:0] TC_ADDR_CAP_H = 4'h7;
	localparam logic [3:0] TC_ADDR_CMPA_L = 4'h8;
	localparam logic [3:0] TC_ADDR_CMPA_H = 4'h9;
	localparam logic [3:0] TC_ADDR_CMPB_L = 4'hA;
	localparam logic [3:0] TC_ADDR_CMPB_H = 4'hB;
	localparam logic [3:0] TC_ADDR_FLAG = 4'hC;
	localparam logic [3:0] TC_ADDR_MASK = 4'hD;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int TC_CTRLA_WGM_LSB = 0;
	localparam int TC_CTRLB_CS_LSB = 0;
	localparam int TC_CTRLB_WGM_LSB = 3;
	localparam int TC_FLAG_OVF_BIT = 0;
	localparam int TC_MASK_OVF_BIT = 0;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] TC_BYTE_RST = 8'h00;
	localparam logic [15:0] TC_WORD_RST = 16'h0000;
	localparam logic [9:0] TC_PRE_RST = 10'h000;

	// ----------------------------------------
	// counter landmarks
	// ----------------------------------------
	localparam logic [15:0] TC_BOTTOM = 16'h0000;
	localparam logic [15:0] TC_MAX = 16'hFFFF;
	localparam logic [15:0] TC_TOP_8 = 16'h00FF;
	localparam logic [15:0] TC_TOP_9 = 16'h01FF;
	localparam logic [15:0] TC_TOP_10 = 16'h03FF;
	localparam logic [15:0] TC_ONE = 16'h0001;

	// ----------------------------------------
	// prescaler taps (divide by 8, 64, 256, 1024)
	// ----------------------------------------
	localparam logic [9:0] TC_PRE_M8 = 10'h007;
	localparam logic [9:0] TC_PRE_M64 = 10'h03F;
	localparam logic [9:0] TC_PRE_M256 = 10'h0FF;
	localparam logic [9:0] TC_PRE_M1024 = 10'h3FF;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		TC_CS_STOP = 3'b000,
		TC_CS_DIV1 = 3'b001,
		TC_CS_DIV8 = 3'b010,
		TC_CS_DIV64 = 3'b011,
		TC_CS_DIV256 = 3'b100,
		TC_CS_DIV1024 = 3'b101,
		TC_CS_EXT_FALL = 3'b110,
		TC_CS_EXT_RISE = 3'b111
	} tc_cs_t;

	typedef enum logic
	{
		TC_UP = 1'b0,
		TC_DOWN = 1'b1
	} tc_dir_t;

endpackage : tc_pkg

/* File: rtl/tc_tick_sel.sv */
// tc_tick_sel: timer tick source selection, prescaler and external edge detect
`timescale 1ns/1ps
module tc_tick_sel
	import tc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [2:0] sel_i,
	input wire logic ext_clk_i,
	output logic tick_o
);

	logic [TC_PRE_W-1:0] pre_reg;
	logic ext_reg;
	logic tick_next;

	// ----------------------------------------
	// free running prescaler
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			pre_reg <= TC_PRE_RST;
		else
			pre_reg <= pre_reg + 10'h001;
	end

	// ----------------------------------------
	// external pin history for edge detect
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ext_reg <= 1'b0;
		else
			ext_reg <= ext_clk_i;
	end

	always_comb
	begin
		case (tc_cs_t'(sel_i))
			TC_CS_STOP: tick_next = 1'b0;
			TC_CS_DIV1: tick_next = 1'b1;
			TC_CS_DIV8: tick_next = (pre_reg[2:0] == TC_PRE_M8[2:0]);
			TC_CS_DIV64: tick_next = (pre_reg[5:0] == TC_PRE_M64[5:0]);
			TC_CS_DIV256: tick_next = (pre_reg[7:0] == TC_PRE_M256[7:0]);
			TC_CS_DIV1024: tick_next = (pre_reg == TC_PRE_M1024);
			TC_CS_EXT_FALL: tick_next = ext_reg & ~ext_clk_i;
			TC_CS_EXT_RISE: tick_next = ~ext_reg & ext_clk_i;
			default: tick_next = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			tick_o <= 1'b0;
		else
			tick_o <= tick_next;
	end

endmodule : tc_tick_sel

/* File: rtl/tc_timer16.sv */
// tc_timer16: 16-bit timer counter with byte access through a shared high-byte latch
`timescale 1ns/1ps
module tc_timer16
	import tc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [TC_AW-1:0] addr_i,
	input wire logic [TC_DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [TC_DW-1:0] rdata_o,
	input wire logic ext_clk_i,
	input wire logic capture_i,
	output logic [TC_CW-1:0] count_o,
	output logic at_top_o,
	output logic at_bottom_o,
	output logic dir_o,
	output logic ovf_irq_o
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [TC_DW-1:0] latch_reg;
	logic [TC_CW-1:0] count_reg;
	logic [TC_CW-1:0] count_next;
	logic [TC_CW-1:0] cmpa_reg;
	logic [TC_CW-1:0] cmpb_reg;
	logic [TC_CW-1:0] cap_reg;
	logic [1:0] ctrl_a_reg;
	logic [4:0] ctrl_b_reg;
	logic ovf_reg;
	logic ovf_next;
	logic mask_reg;
	tc_dir_t dir_reg;
	tc_dir_t dir_next;

	logic tick;
	logic [3:0] wgm;
	logic [TC_CW-1:0] top;
	logic dual_slope;
	logic ovf_at_top;
	logic cap_is_top;
	logic ovf_set;
	logic ovf_clr;

	logic wr_cnt_lo;
	logic wr_cap_lo;
	logic wr_cmpa_lo;
	logic wr_cmpb_lo;
	logic wr_hi;
	logic rd_cnt_lo;
	logic rd_cap_lo;

	// ----------------------------------------
	// tick source
	// ----------------------------------------
	tc_tick_sel u_tick
	(
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.sel_i(ctrl_b_reg[TC_CTRLB_CS_LSB +: 3]),
		.ext_clk_i(ext_clk_i),
		.tick_o(tick)
	);

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	// separate low and high byte strobes
	always_comb
	begin
		wr_cnt_lo = wr_i && (addr_i == TC_ADDR_CNT_L);
		wr_cap_lo = wr_i && (addr_i == TC_ADDR_CAP_L);
		wr_cmpa_lo = wr_i && (addr_i == TC_ADDR_CMPA_L);
		wr_cmpb_lo = wr_i && (addr_i == TC_ADDR_CMPB_L);
		// every high-byte write lands in the latch
		wr_hi = wr_i && ((addr_i == TC_ADDR_CNT_H) || (addr_i == TC_ADDR_CAP_H) ||
			(addr_i == TC_ADDR_CMPA_H) || (addr_i == TC_ADDR_CMPB_H));
		rd_cnt_lo = rd_i && (addr_i == TC_ADDR_CNT_L);
		rd_cap_lo = rd_i && (addr_i == TC_ADDR_CAP_L);
	end

	// ----------------------------------------
	// shared high-byte latch
	// ----------------------------------------
	// single latch for all high-byte writes and for count and capture low-byte reads
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			latch_reg <= TC_BYTE_RST;
		else if (wr_hi)
			latch_reg <= wdata_i;
		else if (rd_cnt_lo)
			latch_reg <= count_reg[15:8];
		else if (rd_cap_lo)
			latch_reg <= cap_reg[15:8];
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ctrl_a_reg <= 2'b00;
		else if (wr_i && (addr_i == TC_ADDR_CTRL_A))
			ctrl_a_reg <= wdata_i[TC_CTRLA_WGM_LSB +: 2];
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ctrl_b_reg <= 5'b00000;
		else if (wr_i && (addr_i == TC_ADDR_CTRL_B))
			ctrl_b_reg <= wdata_i[4:0];
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			mask_reg <= 1'b0;
		else if (wr_i && (addr_i == TC_ADDR_MASK))
			mask_reg <= wdata_i[TC_MASK_OVF_BIT];
	end

	// ----------------------------------------
	// waveform mode decode
	// ----------------------------------------
	// mode bits from both control registers
	assign wgm = {ctrl_b_reg[TC_CTRLB_WGM_LSB +: 2], ctrl_a_reg};

	always_comb
	begin
		top = TC_MAX;
		dual_slope = 1'b0;
		ovf_at_top = 1'b0;
		cap_is_top = 1'b0;
		case (wgm)
			4'h0: top = TC_MAX;
			4'h1:
			begin
				top = TC_TOP_8;
				dual_slope = 1'b1;
			end
			4'h2:
			begin
				top = TC_TOP_9;
				dual_slope = 1'b1;
			end
			4'h3:
			begin
				top = TC_TOP_10;
				dual_slope = 1'b1;
			end
			4'h4: top = cmpa_reg;
			4'h5:
			begin
				top = TC_TOP_8;
				ovf_at_top = 1'b1;
			end
			4'h6:
			begin
				top = TC_TOP_9;
				ovf_at_top = 1'b1;
			end
			4'h7:
			begin
				top = TC_TOP_10;
				ovf_at_top = 1'b1;
			end
			4'h8, 4'hA:
			begin
				top = cap_reg;
				dual_slope = 1'b1;
				cap_is_top = 1'b1;
			end
			4'h9, 4'hB:
			begin
				top = cmpa_reg;
				dual_slope = 1'b1;
			end
			4'hC:
			begin
				top = cap_reg;
				cap_is_top = 1'b1;
			end
			4'hE:
			begin
				top = cap_reg;
				ovf_at_top = 1'b1;
				cap_is_top = 1'b1;
			end
			4'hF:
			begin
				top = cmpa_reg;
				ovf_at_top = 1'b1;
			end
			// reserved mode behaves as the plain free run
			default: top = TC_MAX;
		endcase
	end

	// ----------------------------------------
	// counter next value
	// ----------------------------------------
	always_comb
	begin
		count_next = count_reg;
		dir_next = dir_reg;
		ovf_set = 1'b0;
		if (wr_cnt_lo)
			// latch and low byte loaded together
			count_next = {latch_reg, wdata_i};
		// tick moves the counter per mode
		else if (tick)
		begin
			if (dual_slope)
			begin
				if (dir_reg == TC_UP)
				begin
					if (count_reg >= top)
					begin
						dir_next = TC_DOWN;
						count_next = count_reg - TC_ONE;
					end
					else
						count_next = count_reg + TC_ONE;
				end
				else
				begin
					// turn round at the all-zero value
					if (count_reg == TC_BOTTOM)
					begin
						dir_next = TC_UP;
						count_next = count_reg + TC_ONE;
						ovf_set = 1'b1;
					end
					else
						count_next = count_reg - TC_ONE;
				end
			end
			else
			begin
				dir_next = TC_UP;
				// clear at top, else step up
				if (count_reg == top)
					count_next = TC_BOTTOM;
				else
					count_next = count_reg + TC_ONE;
				// fast modes flag at top, others at max
				if (ovf_at_top)
					ovf_set = (count_reg == top);
				else
					ovf_set = (count_reg == TC_MAX);
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			count_reg <= TC_WORD_RST;
		else
			count_reg <= count_next;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			dir_reg <= TC_UP;
		else
			dir_reg <= dir_next;
	end

	// ----------------------------------------
	// compare and capture registers
	// ----------------------------------------
	// compare loads take latch plus low byte
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cmpa_reg <= TC_WORD_RST;
		else if (wr_cmpa_lo)
			cmpa_reg <= {latch_reg, wdata_i};
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cmpb_reg <= TC_WORD_RST;
		else if (wr_cmpb_lo)
			cmpb_reg <= {latch_reg, wdata_i};
	end

	// capture is writable only while it defines top; otherwise it samples the count
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cap_reg <= TC_WORD_RST;
		else if (cap_is_top)
		begin
			if (wr_cap_lo)
				cap_reg <= {latch_reg, wdata_i};
		end
		else if (capture_i)
			cap_reg <= count_reg;
	end

	// ----------------------------------------
	// overflow flag and request
	// ----------------------------------------
	// writing one clears; a set in the same cycle is kept
	assign ovf_clr = wr_i && (addr_i == TC_ADDR_FLAG) && wdata_i[TC_FLAG_OVF_BIT];
	assign ovf_next = ovf_set | (ovf_reg & ~ovf_clr);

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ovf_reg <= 1'b0;
		else
			ovf_reg <= ovf_next;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ovf_irq_o <= 1'b0;
		else
			ovf_irq_o <= ovf_next & mask_reg;
	end

	// ----------------------------------------
	// status outputs
	// ----------------------------------------
	// top and bottom from the coming count
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			at_top_o <= 1'b0;
			at_bottom_o <= 1'b1;
		end
		else
		begin
			at_top_o <= (count_next == top);
			at_bottom_o <= (count_next == TC_BOTTOM);
		end
	end

	assign count_o = count_reg;
	assign dir_o = dir_reg;

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rdata_o <= TC_BYTE_RST;
		else if (rd_i)
		begin
			case (addr_i)
				TC_ADDR_CTRL_A: rdata_o <= {6'b000000, ctrl_a_reg};
				TC_ADDR_CTRL_B: rdata_o <= {3'b000, ctrl_b_reg};
				TC_ADDR_CNT_L: rdata_o <= count_reg[7:0];
				TC_ADDR_CNT_H: rdata_o <= latch_reg;
				TC_ADDR_CAP_L: rdata_o <= cap_reg[7:0];
				TC_ADDR_CAP_H: rdata_o <= latch_reg;
				TC_ADDR_CMPA_L: rdata_o <= cmpa_reg[7:0];
				TC_ADDR_CMPA_H: rdata_o <= cmpa_reg[15:8];
				TC_ADDR_CMPB_L: rdata_o <= cmpb_reg[7:0];
				TC_ADDR_CMPB_H: rdata_o <= cmpb_reg[15:8];
				TC_ADDR_FLAG: rdata_o <= {7'b0000000, ovf_reg};
				TC_ADDR_MASK: rdata_o <= {7'b0000000, mask_reg};
				default: rdata_o <= TC_BYTE_RST;
			endcase
		end
	end

endmodule : tc_timer16

/* File: bench/tc_timer16_checker.sv */
// tc_timer16_checker: port assertions of the 16-bit timer
`timescale 1ns/1ps
module tc_timer16_chk
	import tc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [TC_AW-1:0] addr_i,
	input wire logic [TC_DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [TC_DW-1:0] rdata_o,
	input wire logic ext_clk_i,
	input wire logic capture_i,
	input wire logic [TC_CW-1:0] count_o,
	input wire logic at_top_o,
	input wire logic at_bottom_o,
	input wire logic dir_o,
	input wire logic ovf_irq_o
);
	// ----
	// shadow of latch and settings
	// ----
	logic [7:0] lat_reg;
	logic lat_ok_reg;
	logic [15:0] cmpa_reg;
	logic [4:0] ctlb_reg;
	logic [1:0] ctla_reg;
	logic [1:0] msk_reg;
	logic [1:0] stop_reg;
	logic [1:0] run_reg;
	logic hi_wr;
	logic stopped;
	logic running;

	assign hi_wr = wr_i && (addr_i inside
		{TC_ADDR_CNT_H, TC_ADDR_CAP_H, TC_ADDR_CMPA_H, TC_ADDR_CMPB_H});
	// settings must be steady two cycles, since the tick is registered
	assign stopped = ctlb_reg[2:0] == 3'h0 && &stop_reg;
	assign running = ctlb_reg == 5'h01 && ctla_reg == 2'h0 && &run_reg;

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			lat_reg <= 8'h00;
			lat_ok_reg <= 1'b1;
		end
		else if (hi_wr)
		begin
			lat_reg <= wdata_i;
			lat_ok_reg <= 1'b1;
		end
		else if (rd_i && addr_i == TC_ADDR_CNT_L)
			lat_reg <= count_o[15:8];
		else if (rd_i && addr_i == TC_ADDR_CAP_L)
			lat_ok_reg <= 1'b0;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cmpa_reg <= 16'h0000;
			ctlb_reg <= 5'h00;
			ctla_reg <= 2'h0;
			msk_reg <= 2'h0;
			stop_reg <= 2'h3;
			run_reg <= 2'h0;
		end
		else
		begin
			if (wr_i && addr_i == TC_ADDR_CMPA_L)
				cmpa_reg <= {lat_reg, wdata_i};
			if (wr_i && addr_i == TC_ADDR_CTRL_B)
				ctlb_reg <= wdata_i[4:0];
			if (wr_i && addr_i == TC_ADDR_CTRL_A)
				ctla_reg <= wdata_i[1:0];
			msk_reg[1] <= msk_reg[0];
			if (wr_i && addr_i == TC_ADDR_MASK)
				msk_reg[0] <= wdata_i[0];
			stop_reg <= {stop_reg[0], ctlb_reg[2:0] == 3'h0};
			run_reg <= {run_reg[0], ctlb_reg == 5'h01 && ctla_reg == 2'h0};
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);

	chk_low_write:
	assert property (wr_i && addr_i == TC_ADDR_CNT_L && lat_ok_reg
		|=> count_o == $past({lat_reg, wdata_i}))
		else $error("count not loaded from latch and low byte");
	chk_high_read:
	assert property (rd_i && addr_i == TC_ADDR_CNT_H && lat_ok_reg |=> rdata_o == $past(lat_reg))
		else $error("count high read not served by latch");
	chk_low_read:
	assert property (rd_i && addr_i == TC_ADDR_CNT_L |=> rdata_o == $past(count_o[7:0]))
		else $error("count low read wrong");
	chk_cmp_read:
	assert property (rd_i && addr_i == TC_ADDR_CMPA_H |=> rdata_o == $past(cmpa_reg[15:8]))
		else $error("compare high read not direct");
	chk_bottom_level:
	assert property (at_bottom_o == (count_o == TC_BOTTOM))
		else $error("bottom indication wrong");
	chk_stop_hold:
	assert property (stopped && !(wr_i && addr_i == TC_ADDR_CNT_L) |=> $stable(count_o))
		else $error("count moved while stopped");
	chk_count_step:
	assert property (running && !wr_i |=> count_o == $past(count_o) + TC_ONE)
		else $error("count did not step by one");
	chk_ovf_request:
	assert property (running && !wr_i && count_o == TC_MAX && msk_reg == 2'h3
		|=> ##1 ovf_irq_o)
		else $error("overflow request missing");
	chk_irq_masked:
	assert property (msk_reg == 2'h0 |-> !ovf_irq_o)
		else $error("request while masked");
endmodule : tc_timer16_chk

bind tc_timer16 tc_timer16_chk i_tc_timer16_chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.ext_clk_i(ext_clk_i), .capture_i(capture_i), .count_o(count_o), .at_top_o(at_top_o),
	.at_bottom_o(at_bottom_o), .dir_o(dir_o), .ovf_irq_o(ovf_irq_o));

/* File: bench/tc_cpu_model.sv */
// tc_cpu_model: byte-wide processor side of the timer bus
`timescale 1ns/1ps
module tc_cpu_model
	import tc_pkg::*;
(
	input wire logic ref_clk_i,
	output logic [TC_AW-1:0] addr_o,
	output logic [TC_DW-1:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [TC_DW-1:0] rdata_i
);
	initial
	begin
		addr_o = 4'h0;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	task wr8(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		#1;
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge ref_clk_i);
		#1;
		wr_o = 1'b0;
		// released data shows the inverse, never a stale copy
		wdata_o = ~d;
	endtask : wr8

	task rd8(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		#1;
		addr_o = a;
		rd_o = 1'b1;
		@(posedge ref_clk_i);
		#1;
		d = rdata_i;
		rd_o = 1'b0;
	endtask : rd8

	task wr16(input logic [3:0] lo, input logic [15:0] v);
		wr8(lo + 4'h1, v[15:8]);
		wr8(lo, v[7:0]);
	endtask : wr16

	task rd16(input logic [3:0] lo, output logic [15:0] v);
		rd8(lo, v[7:0]);
		rd8(lo + 4'h1, v[15:8]);
	endtask : rd16
endmodule : tc_cpu_model

/* File: bench/tc_timer16_tb_top.sv */
// tc_timer16_tb_top: self-checking bench of the 16-bit timer
`timescale 1ns/1ps
module tc_timer16_tb_top
	import tc_pkg::*;
;
	logic ref_clk;
	logic resetn;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic ext_clk;
	logic capture;
	logic [15:0] count;
	logic at_top;
	logic at_bottom;
	logic dir;
	logic ovf_irq;
	int fails;
	int checks_done;
	int n;
	logic [7:0] d;
	logic [15:0] v;
	logic [3:0] top_mode [6] = '{4'h5, 4'h6, 4'h7, 4'h4, 4'hC, 4'h1};
	logic [15:0] top_val [6] = '{TC_TOP_8, TC_TOP_9, TC_TOP_10, 16'h0040, 16'h0030, TC_TOP_8};

	tc_timer16 i_tc_timer16 (.ref_clk_i(ref_clk), .resetn_i(resetn), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_clk_i(ext_clk),
		.capture_i(capture), .count_o(count), .at_top_o(at_top), .at_bottom_o(at_bottom),
		.dir_o(dir), .ovf_irq_o(ovf_irq));
	tc_cpu_model i_tc_cpu_model (.ref_clk_i(ref_clk), .addr_o(addr), .wdata_o(wdata),
		.wr_o(wr), .rd_o(rd), .rdata_i(rdata));

	task chk_word(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
		end
	endtask : chk_word

	task chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
		end
	endtask : chk_bit

	task tick1;
		@(posedge ref_clk);
		#1;
	endtask : tick1

	task set_cfg(input logic [3:0] m, input logic [2:0] s);
		i_tc_cpu_model.wr8(TC_ADDR_CTRL_A, {6'h00, m[1:0]});
		i_tc_cpu_model.wr8(TC_ADDR_CTRL_B, {3'h0, m[3:2], s});
	endtask : set_cfg

	task t_reset;
		chk_word(count, TC_WORD_RST);
		chk_bit(at_bottom, 1'b1);
		chk_bit(ovf_irq, 1'b0);
		i_tc_cpu_model.wr8(4'hE, 8'h5A);
		i_tc_cpu_model.rd8(4'hE, d);
		chk_word({8'h00, d}, 16'h0000);
	endtask : t_reset

	task t_count_rw;
		i_tc_cpu_model.wr16(TC_ADDR_CNT_L, 16'h01FF);
		chk_word(count, 16'h01FF);
		repeat (5) tick1();
		chk_word(count, 16'h01FF);
		i_tc_cpu_model.rd16(TC_ADDR_CNT_L, v);
		chk_word(v, 16'h01FF);
	endtask : t_count_rw

	task t_latch;
		i_tc_cpu_model.wr8(TC_ADDR_CMPA_H, 8'h12);
		i_tc_cpu_model.wr8(TC_ADDR_CNT_L, 8'h34);
		chk_word(count, 16'h1234);
		i_tc_cpu_model.wr8(TC_ADDR_CMPB_L, 8'h56);
		i_tc_cpu_model.wr16(TC_ADDR_CMPA_L, 16'hABCD);
		i_tc_cpu_model.rd8(TC_ADDR_CNT_L, d);
		chk_word({8'h00, d}, 16'h0034);
		i_tc_cpu_model.rd8(TC_ADDR_CMPA_H, d);
		chk_word({8'h00, d}, 16'h00AB);
		i_tc_cpu_model.rd8(TC_ADDR_CNT_H, d);
		chk_word({8'h00, d}, 16'h0012);
		i_tc_cpu_model.rd16(TC_ADDR_CMPB_L, v);
		chk_word(v, 16'h1256);
	endtask : t_latch

	task t_capture;
		i_tc_cpu_model.wr16(TC_ADDR_CNT_L, 16'h0777);
		capture = 1'b1;
		tick1();
		capture = 1'b0;
		i_tc_cpu_model.rd16(TC_ADDR_CAP_L, v);
		chk_word(v, 16'h0777);
		i_tc_cpu_model.rd8(TC_ADDR_CNT_H, d);
		chk_word({8'h00, d}, 16'h0007);
	endtask : t_capture

	task t_overflow;
		i_tc_cpu_model.wr8(TC_ADDR_MASK, 8'h01);
		i_tc_cpu_model.wr16(TC_ADDR_CNT_L, 16'hFFFC);
		set_cfg(4'h0, TC_CS_DIV1);
		for (n = 0; n < 20 && ovf_irq !== 1'b1; n++) tick1();
		chk_bit(ovf_irq, 1'b1);
		i_tc_cpu_model.wr16(TC_ADDR_CNT_L, 16'h1000);
		chk_word(count, 16'h1000);
		set_cfg(4'h0, TC_CS_STOP);
		i_tc_cpu_model.rd8(TC_ADDR_FLAG, d);
		chk_word({8'h00, d}, 16'h0001);
		i_tc_cpu_model.wr8(TC_ADDR_FLAG, 8'h01);
		repeat (2) tick1();
		chk_bit(ovf_irq, 1'b0);
	endtask : t_overflow

	task t_ext;
		i_tc_cpu_model.wr16(TC_ADDR_CNT_L, 16'h0000);
		set_cfg(4'h0, TC_CS_EXT_RISE);
		repeat (3)
		begin
			ext_clk = 1'b1;
			repeat (4) tick1();
			ext_clk = 1'b0;
			repeat (4) tick1();
		end
		chk_word(count, 16'h0003);
		set_cfg(4'h0, TC_CS_EXT_FALL);
		ext_clk = 1'b1;
		repeat (4) tick1();
		chk_word(count, 16'h0003);
		ext_clk = 1'b0;
		repeat (4) tick1();
		chk_word(count, 16'h0004);
		set_cfg(4'h0, TC_CS_STOP);
	endtask : t_ext

	task t_tops;
		i_tc_cpu_model.wr16(TC_ADDR_CMPA_L, 16'h0040);
		for (int i = 0; i < 6; i++)
		begin
			set_cfg(top_mode[i], TC_CS_STOP);
			// capture only takes writes once the mode makes it the top
			if (top_mode[i] == 4'hC)
				i_tc_cpu_model.wr16(TC_ADDR_CAP_L, top_val[i]);
			i_tc_cpu_model.wr16(TC_ADDR_CNT_L, top_val[i] - 16'h0003);
			set_cfg(top_mode[i], TC_CS_DIV1);
			for (n = 0; n < 20 && at_top !== 1'b1; n++) tick1();
			chk_bit(at_top, 1'b1);
			chk_word(count, top_val[i]);
			if (top_mode[i] == 4'h1)
			begin
				for (n = 0; n < 4 && dir !== TC_DOWN; n++) tick1();
				chk_bit(dir, TC_DOWN);
			end
			else
			begin
				for (n = 0; n < 4 && at_bottom !== 1'b1; n++) tick1();
				chk_word(count, TC_BOTTOM);
			end
		end
		set_cfg(4'h0, TC_CS_STOP);
	endtask : t_tops

	task give_verdict;
		if (fails == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	initial
	begin
		resetn = 1'b0;
		ext_clk = 1'b0;
		capture = 1'b0;
		fails = 0;
		checks_done = 0;
		repeat (20) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		t_reset();
		t_count_rw();
		t_latch();
		t_capture();
		t_overflow();
		t_ext();
		t_tops();
		give_verdict();
	end

	// the tests take under a thousand cycles; ten thousand means a hang
	initial
	begin
		#400000;
		fails++;
		give_verdict();
	end
endmodule : tc_timer16_tb_top
